// File: lcr_consts.svh
// Command encodings, register reset values and field positions for the LCD command decoder
`ifndef LCR_CONSTS_SVH
`define LCR_CONSTS_SVH
`define LCR_RST_SCROLL     7'h00
`define LCR_RST_FIXED      4'h0
`define LCR_RST_BIAS_RATIO 2'h2
`define LCR_RST_TEMP_COEF  2'h0
`define LCR_RST_BIAS_TRIM  8'hB2
`define LCR_RST_POWER      4'hD
`define LCR_RST_DISPLAY    3'h0
`define LCR_RST_ADDR_CTRL  5'h01
`define LCR_RST_WIN_SCOL   8'h00
`define LCR_RST_WIN_SPAGE  5'h00
`define LCR_RST_WIN_ECOL   8'h9F
`define LCR_RST_WIN_EPAGE  5'h1F
`define LCR_RST_SCAN_END   7'h7F
`define LCR_RST_PART_START 7'h00
`define LCR_RST_PART_END   7'h7F
`define LCR_RST_PANEL      9'h008
`define LCR_PAGE_MAX       5'h1F
`define LCR_COL_LAST       8'h9F
`define LCR_AC_WRAP        0
`define LCR_AC_ORDER       1
`define LCR_AC_PDIR        2
`define LCR_AC_CURSOR      3
`define LCR_AC_WINDOW      4
`define LCR_PD_FIXED_SHOW  0
`define LCR_PD_MIRROR_COL  1
`define LCR_PD_MIRROR_ROW  2
`define LCR_OP_RESET       2'h0
`define LCR_OP_SLEEP       2'h2
`define LCR_OP_NORMAL      2'h3
`define LCR_RESET_CYCLES   4'h8
`define LCR_CMD_SYS_RESET  8'hE2
`define LCR_CMD_NOP        8'hE3
`define LCR_CMD_CUR_CLR    8'hEE
`define LCR_CMD_CUR_SET    8'hEF
`define LCR_CMD_BIAS_TRIM  8'h81
`define LCR_CMD_SCAN_END   8'hF1
`define LCR_CMD_PART_START 8'hF2
`define LCR_CMD_PART_END   8'hF3
`define LCR_CMD_WIN_SCOL   8'hF4
`define LCR_CMD_WIN_SPAGE  8'hF5
`define LCR_CMD_WIN_ECOL   8'hF6
`define LCR_CMD_WIN_EPAGE  8'hF7
`endif

// File: lcr_pkg.sv
// Types shared by the LCD command decoder modules
package lcr_pkg;
  typedef enum logic [3:0] {
    SEC_NONE, SEC_VENDOR, SEC_BIAS_TRIM, SEC_TEST, SEC_SCAN_END, SEC_PART_START,
    SEC_PART_END, SEC_WIN_SCOL, SEC_WIN_SPAGE, SEC_WIN_ECOL, SEC_WIN_EPAGE
  } lcr_second_t;
  typedef struct packed {
    logic       sel_data;
    logic       is_read;
    logic [7:0] value;
  } lcr_host_byte_t;
  typedef struct packed {
    logic [7:0] column;
    logic [4:0] page;
  } lcr_addr_t;
endpackage

// File: lcr_addr_step.sv
// Next RAM address after a display access, honouring order, wrap, direction and window
module lcr_addr_step
  import lcr_pkg::*;
(
  // Current address and controls
  input  wire lcr_addr_t  cur,
  input  wire logic [4:0] addr_ctrl,
  input  wire lcr_addr_t  win_lo,
  input  wire lcr_addr_t  win_hi,
  // Next address
  output lcr_addr_t       nxt
);
  `include "lcr_consts.svh"
  wire       wrap    = addr_ctrl[`LCR_AC_WRAP] & ~addr_ctrl[`LCR_AC_CURSOR];
  wire       row_ord = addr_ctrl[`LCR_AC_ORDER];
  wire       dec     = addr_ctrl[`LCR_AC_PDIR];
  // Window disabled behaves as full-RAM window
  wire [7:0] col_lo  = addr_ctrl[`LCR_AC_WINDOW] ? win_lo.column : 8'h00;
  wire [7:0] col_hi  = addr_ctrl[`LCR_AC_WINDOW] ? win_hi.column : `LCR_COL_LAST;
  wire [4:0] pg_lo   = addr_ctrl[`LCR_AC_WINDOW] ? win_lo.page : 5'h00;
  wire [4:0] pg_hi   = addr_ctrl[`LCR_AC_WINDOW] ? win_hi.page : `LCR_PAGE_MAX;
  wire       col_end = cur.column == col_hi;
  wire       pg_end  = dec ? (cur.page == pg_lo) : (cur.page == pg_hi);
  wire [7:0] col_inc = cur.column + 8'h01;
  // Page step wraps to the opposite end at the boundary
  wire [4:0] pg_step = pg_end ? (dec ? pg_hi : pg_lo) : (dec ? cur.page - 5'h01 : cur.page + 5'h01);
  wire [7:0] col_wr  = col_end ? col_lo : col_inc;
  always_comb begin
    nxt = cur;
    if (!row_ord) begin
      if (!col_end) begin
        nxt.column = col_inc;
      end else if (wrap) begin
        nxt.column = col_lo;
        nxt.page   = pg_step;
      end
    end else begin
      if (!pg_end) begin
        nxt.page = pg_step;
      end else if (wrap) begin
        nxt.page   = pg_step;
        nxt.column = col_wr;
      end
    end
  end
endmodule

// File: lcr_status_fmt.sv
// Formats the status byte returned to the host
module lcr_status_fmt (
  // Status sources
  input  wire logic       pin_level,
  input  wire logic       mirror_col,
  input  wire logic       mirror_row,
  input  wire logic       wrap_on,
  input  wire logic       display_on,
  input  wire logic [1:0] trim_top,
  // Formatted byte
  output logic [7:0]      status
);
  assign status = {pin_level, mirror_col, mirror_row, wrap_on, display_on, trim_top, 1'b1};
endmodule

// File: lcr_command_decoder.sv
// Host command decoder and control register bank of the LCD controller-driver
module lcr_command_decoder
  import lcr_pkg::*;
#(
  parameter int RESET_CYCLES = 8
) (
  // Clock and reset
  input  wire logic       CLOCK,
  input  wire logic       ARST_N,
  input  wire logic       RESET_PIN_N,
  // Host byte port
  input  wire logic       HOST_STROBE,
  input  wire logic       HOST_SEL_DATA,
  input  wire logic       HOST_READ,
  input  wire logic [7:0] HOST_WDATA,
  output logic [7:0]      HOST_RDATA,
  output logic            HOST_RVALID,
  input  wire logic       VENDOR_PIN,
  // Display RAM access
  output logic            RAM_WE,
  output logic            RAM_RE,
  output logic [7:0]      RAM_COLUMN,
  output logic [4:0]      RAM_PAGE,
  output logic [7:0]      RAM_WDATA,
  input  wire logic [7:0] RAM_RDATA,
  // Register outputs to the panel logic
  output logic [6:0]      SCROLL_LINE,
  output logic [3:0]      FIXED_LINE_COUNT,
  output logic [1:0]      BIAS_RATIO,
  output logic [1:0]      TEMP_COEFFICIENT,
  output logic [7:0]      BIAS_TRIM_LEVEL,
  output logic [3:0]      POWER_DRIVE_CONFIG,
  output logic [2:0]      DISPLAY_CONTROL,
  output logic [4:0]      ADDRESS_CONTROL,
  output logic [6:0]      COM_SCAN_END,
  output logic [6:0]      PARTIAL_START_ROW,
  output logic [6:0]      PARTIAL_END_ROW,
  output logic [8:0]      PANEL_DRIVE_CONTROL,
  output logic [7:0]      MUX_RATE,
  output logic            FIXED_ROWS_SHOWN,
  // State
  output logic [1:0]      OPERATING_STATE,
  output logic            RESET_PENDING
);
  `include "lcr_consts.svh"

  lcr_host_byte_t hb;
  lcr_second_t    second;
  lcr_addr_t      addr;
  lcr_addr_t      addr_next;
  lcr_addr_t      win_lo;
  lcr_addr_t      win_hi;
  logic [7:0]     cursor_return_column;
  logic [3:0]     rst_count;
  logic [7:0]     status_byte;

  assign hb = '{sel_data: HOST_SEL_DATA, is_read: HOST_READ, value: HOST_WDATA};

  // Decode: host ignored while reset is pending
  wire accept   = HOST_STROBE & ~RESET_PENDING;
  wire cmd_wr   = accept & ~hb.sel_data & ~hb.is_read;
  wire stat_rd  = accept & ~hb.sel_data & hb.is_read;
  wire data_wr  = accept & hb.sel_data & ~hb.is_read;
  wire data_rd  = accept & hb.sel_data & hb.is_read;
  wire first_wr = cmd_wr & (second == SEC_NONE);
  wire sec_wr   = cmd_wr & (second != SEC_NONE);
  wire [7:0] c  = hb.value;
  wire cursor_on = ADDRESS_CONTROL[`LCR_AC_CURSOR];

  wire is_col_lo   = first_wr & (c[7:4] == 4'h0);
  wire is_col_hi   = first_wr & (c[7:4] == 4'h1);
  wire is_temp     = first_wr & (c[7:2] == 6'b001001);
  wire is_load     = first_wr & (c[7:2] == 6'b001010);
  wire is_pump     = first_wr & (c[7:2] == 6'b001011);
  wire is_vendor   = first_wr & (c[7:1] == 7'b0011000);
  wire is_scr_lo   = first_wr & (c[7:4] == 4'h4);
  wire is_scr_hi   = first_wr & (c[7:4] == 4'h5);
  wire is_page     = first_wr & (c[7:5] == 3'b011);
  wire is_trim     = first_wr & (c == `LCR_CMD_BIAS_TRIM);
  wire is_partial  = first_wr & (c[7:2] == 6'b100001);
  wire is_addr     = first_wr & (c[7:3] == 5'b10001);
  wire is_fixed    = first_wr & (c[7:4] == 4'h9);
  wire is_rate     = first_wr & (c[7:2] == 6'b101000);
  wire is_allon    = first_wr & (c[7:1] == 7'b1010010);
  wire is_inv      = first_wr & (c[7:1] == 7'b1010011);
  wire is_disp     = first_wr & (c[7:1] == 7'b1010111);
  wire is_map      = first_wr & (c[7:3] == 5'b11000);
  wire is_gray     = first_wr & (c[7:2] == 6'b110100);
  wire is_sysrst   = first_wr & (c == `LCR_CMD_SYS_RESET);
  wire is_test     = first_wr & (c[7:2] == 6'b111001);
  wire is_bias     = first_wr & (c[7:2] == 6'b111010);
  wire is_cur_clr  = first_wr & (c == `LCR_CMD_CUR_CLR);
  wire is_cur_set  = first_wr & (c == `LCR_CMD_CUR_SET);
  wire is_dbl_row  = first_wr & (c[7:2] == 6'b111100) & (c[1:0] != 2'b00);
  wire is_dbl_win  = first_wr & (c[7:2] == 6'b111101);
  // Window enable sits just above the double-byte window opcodes
  wire is_win_en   = first_wr & (c[7:1] == 7'b1111100);

  // Soft reset pulses the same restore path as the pin and power-up
  wire soft_reset = is_sysrst | ~RESET_PIN_N;

  // Second byte owner selection
  lcr_second_t next_second;
  always_comb begin
    next_second = SEC_NONE;
    if (is_vendor) begin
      next_second = SEC_VENDOR;
    end else if (is_trim) begin
      next_second = SEC_BIAS_TRIM;
    end else if (is_test) begin
      next_second = SEC_TEST;
    end else if (is_dbl_row) begin
      next_second = (c[1:0] == 2'b01) ? SEC_SCAN_END : (c[1:0] == 2'b10) ? SEC_PART_START : SEC_PART_END;
    end else if (is_dbl_win) begin
      unique case (c[1:0])
        2'b00: next_second = SEC_WIN_SCOL;
        2'b01: next_second = SEC_WIN_SPAGE;
        2'b10: next_second = SEC_WIN_ECOL;
        2'b11: next_second = SEC_WIN_EPAGE;
      endcase
    end
  end

  // Address stepping after display data access
  lcr_addr_step u_step (
    .cur       (addr),
    .addr_ctrl (ADDRESS_CONTROL),
    .win_lo    (win_lo),
    .win_hi    (win_hi),
    .nxt       (addr_next)
  );

  wire step_en = data_wr | (data_rd & ~cursor_on);

  lcr_addr_t next_addr;
  always_comb begin
    next_addr = addr;
    if (is_col_lo) begin
      next_addr.column = {addr.column[7:4], c[3:0]};
    end else if (is_col_hi) begin
      next_addr.column = {c[3:0], addr.column[3:0]};
    end else if (is_page) begin
      next_addr.page = c[4:0];
    end else if (is_cur_clr) begin
      next_addr.column = cursor_return_column;
    end else if (step_en) begin
      next_addr = addr_next;
    end
  end

  // Reset sequencing: pending flag held for a fixed count
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_count <= 4'(RESET_CYCLES);
    end else if (soft_reset) begin
      rst_count <= 4'(RESET_CYCLES);
    end else if (rst_count != 4'h0) begin
      rst_count <= rst_count - 4'h1;
    end
  end
  assign RESET_PENDING = rst_count != 4'h0;
  assign OPERATING_STATE = RESET_PENDING ? `LCR_OP_RESET
                         : DISPLAY_CONTROL[2] ? `LCR_OP_NORMAL : `LCR_OP_SLEEP;

  // Control registers; every one returns to its default on any reset
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      second               <= SEC_NONE;
      addr                 <= '0;
      cursor_return_column <= 8'h00;
      SCROLL_LINE          <= `LCR_RST_SCROLL;
      FIXED_LINE_COUNT     <= `LCR_RST_FIXED;
      BIAS_RATIO           <= `LCR_RST_BIAS_RATIO;
      TEMP_COEFFICIENT     <= `LCR_RST_TEMP_COEF;
      BIAS_TRIM_LEVEL      <= `LCR_RST_BIAS_TRIM;
      POWER_DRIVE_CONFIG   <= `LCR_RST_POWER;
      DISPLAY_CONTROL      <= `LCR_RST_DISPLAY;
      ADDRESS_CONTROL      <= `LCR_RST_ADDR_CTRL;
      win_lo               <= '{column: `LCR_RST_WIN_SCOL, page: `LCR_RST_WIN_SPAGE};
      win_hi               <= '{column: `LCR_RST_WIN_ECOL, page: `LCR_RST_WIN_EPAGE};
      COM_SCAN_END         <= `LCR_RST_SCAN_END;
      PARTIAL_START_ROW    <= `LCR_RST_PART_START;
      PARTIAL_END_ROW      <= `LCR_RST_PART_END;
      PANEL_DRIVE_CONTROL  <= `LCR_RST_PANEL;
    end else if (soft_reset) begin
      second               <= SEC_NONE;
      addr                 <= '0;
      cursor_return_column <= 8'h00;
      SCROLL_LINE          <= `LCR_RST_SCROLL;
      FIXED_LINE_COUNT     <= `LCR_RST_FIXED;
      BIAS_RATIO           <= `LCR_RST_BIAS_RATIO;
      TEMP_COEFFICIENT     <= `LCR_RST_TEMP_COEF;
      BIAS_TRIM_LEVEL      <= `LCR_RST_BIAS_TRIM;
      POWER_DRIVE_CONFIG   <= `LCR_RST_POWER;
      DISPLAY_CONTROL      <= `LCR_RST_DISPLAY;
      ADDRESS_CONTROL      <= `LCR_RST_ADDR_CTRL;
      win_lo               <= '{column: `LCR_RST_WIN_SCOL, page: `LCR_RST_WIN_SPAGE};
      win_hi               <= '{column: `LCR_RST_WIN_ECOL, page: `LCR_RST_WIN_EPAGE};
      COM_SCAN_END         <= `LCR_RST_SCAN_END;
      PARTIAL_START_ROW    <= `LCR_RST_PART_START;
      PARTIAL_END_ROW      <= `LCR_RST_PART_END;
      PANEL_DRIVE_CONTROL  <= `LCR_RST_PANEL;
    end else begin
      addr <= next_addr;
      if (cmd_wr) begin
        second <= next_second;
      end
      // Second bytes of double-byte commands
      if (sec_wr) begin
        unique case (second)
          SEC_BIAS_TRIM:  BIAS_TRIM_LEVEL   <= c;
          SEC_SCAN_END:   COM_SCAN_END      <= c[6:0];
          SEC_PART_START: PARTIAL_START_ROW <= c[6:0];
          SEC_PART_END:   PARTIAL_END_ROW   <= c[6:0];
          SEC_WIN_SCOL:   win_lo.column     <= c;
          SEC_WIN_SPAGE:  win_lo.page       <= c[4:0];
          SEC_WIN_ECOL:   win_hi.column     <= c;
          SEC_WIN_EPAGE:  win_hi.page       <= c[4:0];
          // Vendor and test payloads are swallowed without effect
          default: ;
        endcase
      end
      if (is_scr_lo) SCROLL_LINE[3:0] <= c[3:0];
      if (is_scr_hi) SCROLL_LINE[6:4] <= c[2:0];
      if (is_fixed) FIXED_LINE_COUNT <= c[3:0];
      if (is_temp) TEMP_COEFFICIENT <= c[1:0];
      if (is_bias) BIAS_RATIO <= c[1:0];
      if (is_load) POWER_DRIVE_CONFIG[1:0] <= c[1:0];
      if (is_pump) POWER_DRIVE_CONFIG[3:2] <= c[1:0];
      if (is_inv) DISPLAY_CONTROL[0] <= c[0];
      if (is_allon) DISPLAY_CONTROL[1] <= c[0];
      if (is_disp) DISPLAY_CONTROL[2] <= c[0];
      if (is_addr) ADDRESS_CONTROL[2:0] <= c[2:0];
      if (is_win_en) ADDRESS_CONTROL[`LCR_AC_WINDOW] <= c[0];
      if (is_cur_set) begin
        ADDRESS_CONTROL[`LCR_AC_CURSOR] <= 1'b1;
        cursor_return_column            <= addr.column;
      end
      if (is_cur_clr) ADDRESS_CONTROL[`LCR_AC_CURSOR] <= 1'b0;
      if (is_rate) PANEL_DRIVE_CONTROL[4:3] <= c[1:0];
      if (is_gray) PANEL_DRIVE_CONTROL[6:5] <= c[1:0];
      if (is_partial) PANEL_DRIVE_CONTROL[8:7] <= c[1:0];
      if (is_map) PANEL_DRIVE_CONTROL[2:0] <= c[2:0];
    end
  end

  // Partial display row gating and multiplex rate
  assign FIXED_ROWS_SHOWN = ~PANEL_DRIVE_CONTROL[8]
                          | PANEL_DRIVE_CONTROL[`LCR_PD_FIXED_SHOW];
  wire [7:0] mux_full = {1'b0, COM_SCAN_END} + 8'h01;
  wire [7:0] mux_part = {1'b0, PARTIAL_END_ROW} - {1'b0, PARTIAL_START_ROW} + 8'h01;
  assign MUX_RATE = (PANEL_DRIVE_CONTROL[8:7] == 2'b11) ? mux_part : mux_full;

  // Status formatting
  lcr_status_fmt u_status (
    .pin_level  (VENDOR_PIN),
    .mirror_col (PANEL_DRIVE_CONTROL[`LCR_PD_MIRROR_COL]),
    .mirror_row (PANEL_DRIVE_CONTROL[`LCR_PD_MIRROR_ROW]),
    .wrap_on    (ADDRESS_CONTROL[`LCR_AC_WRAP]),
    .display_on (DISPLAY_CONTROL[2]),
    .trim_top   (BIAS_TRIM_LEVEL[7:6]),
    .status     (status_byte)
  );

  // Read data and RAM strobes; RAM read data arrives the next cycle
  logic ram_rd_d;
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      HOST_RDATA  <= 8'h00;
      HOST_RVALID <= 1'b0;
      ram_rd_d    <= 1'b0;
    end else begin
      ram_rd_d    <= data_rd;
      HOST_RVALID <= stat_rd | ram_rd_d;
      if (stat_rd) begin
        HOST_RDATA <= status_byte;
      end else if (ram_rd_d) begin
        HOST_RDATA <= RAM_RDATA;
      end
    end
  end

  assign RAM_WE     = data_wr;
  assign RAM_RE     = data_rd;
  assign RAM_COLUMN = addr.column;
  assign RAM_PAGE   = addr.page;
  assign RAM_WDATA  = hb.value;
endmodule

// File: lcr_ram_model.sv
// Display RAM model answering the decoder's RAM strobes
module lcr_ram_model (
  // Clock
  input  wire logic       clock,
  // Access from the decoder
  input  wire logic       we,
  input  wire logic       re,
  input  wire logic [7:0] column,
  input  wire logic [4:0] page,
  input  wire logic [7:0] wdata,
  // Read answer
  output logic      [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:8191];
  initial rdata = 8'h00;
  always @(posedge clock) begin
    if (we) begin
      mem[{page, column}] <= wdata;
    end
    // Data is good for one cycle only; inverting afterwards exposes late sampling
    if (re) begin
      rdata <= mem[{page, column}];
    end else begin
      rdata <= ~rdata;
    end
  end
endmodule

// File: lcr_cmd_chk.sv
// Port assertions for the LCD command decoder, bound to its top module
module lcr_cmd_chk #(
  parameter int RESET_CYCLES = 8
) (
  // Clock and reset
  input wire logic       CLOCK,
  input wire logic       ARST_N,
  // Host side
  input wire logic       HOST_STROBE,
  input wire logic       HOST_SEL_DATA,
  input wire logic       HOST_READ,
  input wire logic [7:0] HOST_WDATA,
  input wire logic [7:0] HOST_RDATA,
  input wire logic       HOST_RVALID,
  input wire logic       VENDOR_PIN,
  // RAM side
  input wire logic       RAM_WE,
  input wire logic       RAM_RE,
  input wire logic [7:0] RAM_COLUMN,
  input wire logic [4:0] RAM_PAGE,
  input wire logic [7:0] RAM_WDATA,
  input wire logic [7:0] RAM_RDATA,
  // Registers and state
  input wire logic [7:0] BIAS_TRIM_LEVEL,
  input wire logic [2:0] DISPLAY_CONTROL,
  input wire logic [4:0] ADDRESS_CONTROL,
  input wire logic [6:0] COM_SCAN_END,
  input wire logic [6:0] PARTIAL_START_ROW,
  input wire logic [6:0] PARTIAL_END_ROW,
  input wire logic [8:0] PANEL_DRIVE_CONTROL,
  input wire logic [7:0] MUX_RATE,
  input wire logic [1:0] OPERATING_STATE,
  input wire logic       RESET_PENDING
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!ARST_N);
  logic [7:0] pend_run;
  wire  [7:0] status_now = {VENDOR_PIN, PANEL_DRIVE_CONTROL[1], PANEL_DRIVE_CONTROL[2], ADDRESS_CONTROL[0],
                            DISPLAY_CONTROL[2], BIAS_TRIM_LEVEL[7:6], 1'b1};
  // Saturates so a stuck pending flag cannot wrap the count back under the limit
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      pend_run <= 8'h00;
    end else if (!RESET_PENDING) begin
      pend_run <= 8'h00;
    end else if (pend_run != 8'hFF) begin
      pend_run <= pend_run + 8'h01;
    end
  end
  sequence s_host(logic s, logic r);
    HOST_STROBE && !RESET_PENDING && HOST_SEL_DATA == s && HOST_READ == r;
  endsequence
  AST_PEND_LEN: assert property ($fell(RESET_PENDING) |-> pend_run >= RESET_CYCLES)
    else $error("reset pending ended early");
  AST_OP_STATE: assert property (OPERATING_STATE == (RESET_PENDING ? 2'h0 : {1'b1, DISPLAY_CONTROL[2]}))
    else $error("operating state wrong");
  AST_STATUS: assert property (s_host(1'b0, 1'b1) |=> HOST_RVALID && HOST_RDATA == $past(status_now))
    else $error("status byte wrong");
  AST_DATA_WRITE: assert property (s_host(1'b1, 1'b0) |-> RAM_WE && RAM_WDATA == HOST_WDATA)
    else $error("data write not passed to RAM");
  AST_DATA_READ: assert property (s_host(1'b1, 1'b1) |-> RAM_RE ##2 (HOST_RVALID && HOST_RDATA == $past(RAM_RDATA)))
    else $error("data read answer wrong");
  AST_PEND_IGNORE: assert property (RESET_PENDING && HOST_STROBE |-> !RAM_WE && !RAM_RE ##1 !HOST_RVALID)
    else $error("strobe acted on during reset");
  AST_CUR_READ: assert property (RAM_RE && ADDRESS_CONTROL[3] |=> $stable(RAM_COLUMN))
    else $error("read advanced column in cursor mode");
  AST_COL_STEP: assert property (RAM_WE && ADDRESS_CONTROL[4:1] ==? 4'b0?_?0 && RAM_COLUMN < 8'h9F
    |=> RAM_COLUMN == $past(RAM_COLUMN) + 8'h01) else $error("column did not step on write");
  AST_WRAP: assert property (RAM_WE && ADDRESS_CONTROL == 5'h01 && RAM_COLUMN == 8'h9F
    |=> RAM_COLUMN == 8'h00 && RAM_PAGE == $past(RAM_PAGE) + 5'h01) else $error("column wrap wrong");
  AST_MUX: assert property (MUX_RATE == (PANEL_DRIVE_CONTROL[8:7] == 2'b11 ?
    {1'b0, PARTIAL_END_ROW - PARTIAL_START_ROW} + 8'h01 : {1'b0, COM_SCAN_END} + 8'h01)) else $error("mux rate wrong");
endmodule
bind lcr_command_decoder lcr_cmd_chk #(.RESET_CYCLES(RESET_CYCLES)) u_chk (.CLOCK, .ARST_N, .HOST_STROBE,
  .HOST_SEL_DATA, .HOST_READ, .HOST_WDATA, .HOST_RDATA, .HOST_RVALID, .VENDOR_PIN, .RAM_WE, .RAM_RE, .RAM_COLUMN,
  .RAM_PAGE, .RAM_WDATA, .RAM_RDATA, .BIAS_TRIM_LEVEL, .DISPLAY_CONTROL, .ADDRESS_CONTROL, .COM_SCAN_END,
  .PARTIAL_START_ROW, .PARTIAL_END_ROW, .PANEL_DRIVE_CONTROL, .MUX_RATE, .OPERATING_STATE, .RESET_PENDING);

// File: lcr_command_decoder_tb_top.sv
// Self-checking bench for the LCD command decoder
`include "lcr_consts.svh"
module lcr_command_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic       CLOCK, ARST_N = 1'b0, RESET_PIN_N = 1'b1, HOST_STROBE = 1'b0;
  logic       HOST_SEL_DATA = 1'b0, HOST_READ = 1'b0, VENDOR_PIN = 1'b0;
  logic [7:0] HOST_WDATA = 8'h00;
  logic [7:0] HOST_RDATA, RAM_COLUMN, RAM_WDATA, RAM_RDATA, BIAS_TRIM_LEVEL, MUX_RATE;
  logic       HOST_RVALID, RAM_WE, RAM_RE, FIXED_ROWS_SHOWN, RESET_PENDING;
  logic [6:0] SCROLL_LINE, COM_SCAN_END, PARTIAL_START_ROW, PARTIAL_END_ROW;
  logic [4:0] RAM_PAGE, ADDRESS_CONTROL;
  logic [3:0] FIXED_LINE_COUNT, POWER_DRIVE_CONFIG;
  logic [1:0] BIAS_RATIO, TEMP_COEFFICIENT, OPERATING_STATE;
  logic [2:0] DISPLAY_CONTROL;
  logic [8:0] PANEL_DRIVE_CONTROL;
  int         bad_count = 0, n_compared = 0, cycles = 0, i;
  lcr_command_decoder #(.RESET_CYCLES(8)) dut (.CLOCK, .ARST_N, .RESET_PIN_N, .HOST_STROBE, .HOST_SEL_DATA,
    .HOST_READ, .HOST_WDATA, .HOST_RDATA, .HOST_RVALID, .VENDOR_PIN, .RAM_WE, .RAM_RE, .RAM_COLUMN, .RAM_PAGE,
    .RAM_WDATA, .RAM_RDATA, .SCROLL_LINE, .FIXED_LINE_COUNT, .BIAS_RATIO, .TEMP_COEFFICIENT, .BIAS_TRIM_LEVEL,
    .POWER_DRIVE_CONFIG, .DISPLAY_CONTROL, .ADDRESS_CONTROL, .COM_SCAN_END, .PARTIAL_START_ROW,
    .PARTIAL_END_ROW, .PANEL_DRIVE_CONTROL, .MUX_RATE, .FIXED_ROWS_SHOWN, .OPERATING_STATE, .RESET_PENDING);
  lcr_ram_model ram (.clock(CLOCK), .we(RAM_WE), .re(RAM_RE), .column(RAM_COLUMN), .page(RAM_PAGE),
    .wdata(RAM_WDATA), .rdata(RAM_RDATA));
  initial begin
    CLOCK = 1'b0;
    forever #50 CLOCK = ~CLOCK;
  end
  task automatic finish_test;
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(posedge CLOCK) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      finish_test;
    end
  end
  task automatic chk(input string n, input logic [79:0] e, input logic [79:0] g);
    n_compared++;
    if (g !== e) begin
      $display("BAD %s expected %0h seen %0h", n, e, g);
      bad_count++;
    end
  endtask
  // One idle cycle between bytes keeps each strobe a clean single-cycle pulse
  task automatic xfer(input logic s, input logic r, input logic [7:0] b);
    @(posedge CLOCK);
    HOST_STROBE <= 1'b1;
    HOST_SEL_DATA <= s;
    HOST_READ <= r;
    HOST_WDATA <= b;
    @(posedge CLOCK);
    HOST_STROBE <= 1'b0;
    #1;
  endtask
  task automatic cmd(input logic [7:0] b);
    xfer(1'b0, 1'b0, b);
  endtask
  task automatic rd(input logic s, input logic [7:0] e, input string n);
    int k;
    xfer(s, 1'b1, 8'h00);
    for (k = 0; k < 4 && HOST_RVALID !== 1'b1; k++) begin
      @(posedge CLOCK);
      #1;
    end
    chk("read valid", 1'b1, HOST_RVALID);
    chk(n, e, HOST_RDATA);
  endtask
  task automatic wait_ready;
    int k;
    for (k = 0; k < 40 && RESET_PENDING !== 1'b0; k++) begin
      @(posedge CLOCK);
      #1;
    end
    chk("reset pending", 1'b0, RESET_PENDING);
  endtask
  task automatic chk_def(input string n);
    chk(n, {`LCR_RST_SCROLL, `LCR_RST_FIXED, `LCR_RST_BIAS_RATIO, `LCR_RST_TEMP_COEF, `LCR_RST_BIAS_TRIM,
      `LCR_RST_POWER, `LCR_RST_DISPLAY, `LCR_RST_ADDR_CTRL, `LCR_RST_SCAN_END, `LCR_RST_PART_START,
      `LCR_RST_PART_END, `LCR_RST_PANEL, 8'h00, 5'h00, `LCR_OP_SLEEP},
      {SCROLL_LINE, FIXED_LINE_COUNT, BIAS_RATIO, TEMP_COEFFICIENT, BIAS_TRIM_LEVEL, POWER_DRIVE_CONFIG,
      DISPLAY_CONTROL, ADDRESS_CONTROL, COM_SCAN_END, PARTIAL_START_ROW, PARTIAL_END_ROW, PANEL_DRIVE_CONTROL,
      RAM_COLUMN, RAM_PAGE, OPERATING_STATE});
  endtask
  initial begin
    repeat (6) @(posedge CLOCK);
    ARST_N <= 1'b1;
    wait_ready;
    chk_def("power-up defaults");
    $display("test defaults done");
    for (i = 0; i < 4; i++) begin
      cmd(8'h24 + i[7:0]);
      chk("temp coef", i[1:0], TEMP_COEFFICIENT);
      cmd(8'hE8 + i[7:0]);
      chk("bias ratio", i[1:0], BIAS_RATIO);
      cmd(8'h28 + i[7:0]);
      chk("panel load", i[1:0], POWER_DRIVE_CONFIG[1:0]);
      cmd(8'hA0 + i[7:0]);
      chk("line rate", i[1:0], PANEL_DRIVE_CONTROL[4:3]);
      cmd(8'hD0 + i[7:0]);
      chk("gray level", i[1:0], PANEL_DRIVE_CONTROL[6:5]);
    end
    cmd(8'hE8);
    for (i = 0; i < 4; i++) begin
      cmd(8'h2C + i[7:0]);
      chk("pump", i[1:0], POWER_DRIVE_CONFIG[3:2]);
    end
    for (i = 0; i < 2; i++) begin
      cmd(8'hA6 + i[7:0]);
      chk("invert", i[0], DISPLAY_CONTROL[0]);
      cmd(8'hA4 + i[7:0]);
      chk("all on", i[0], DISPLAY_CONTROL[1]);
      cmd(8'hAE + i[7:0]);
      chk("display on", {i[0], 1'b1, i[0]}, {DISPLAY_CONTROL[2], OPERATING_STATE});
    end
    cmd(8'h45);
    cmd(8'h56);
    chk("scroll", 7'h65, SCROLL_LINE);
    cmd(8'h9A);
    chk("fixed lines", 4'hA, FIXED_LINE_COUNT);
    cmd(8'hC7);
    chk("mapping", 3'h7, PANEL_DRIVE_CONTROL[2:0]);
    cmd(8'h81);
    cmd(8'h5A);
    chk("bias trim", 8'h5A, BIAS_TRIM_LEVEL);
    cmd(8'hF1);
    cmd(8'h5F);
    cmd(8'hF2);
    cmd(8'h10);
    cmd(8'hF3);
    cmd(8'h30);
    chk("rows", {7'h5F, 7'h10, 7'h30}, {COM_SCAN_END, PARTIAL_START_ROW, PARTIAL_END_ROW});
    cmd(8'hC6);
    cmd(8'h87);
    chk("partial mux", {2'b11, 8'h21, 1'b0}, {PANEL_DRIVE_CONTROL[8:7], MUX_RATE, FIXED_ROWS_SHOWN});
    cmd(8'h86);
    chk("partial same mux", {2'b10, 8'h60, 1'b0}, {PANEL_DRIVE_CONTROL[8:7], MUX_RATE, FIXED_ROWS_SHOWN});
    cmd(8'h84);
    chk("full mux", {2'b00, 8'h60, 1'b1}, {PANEL_DRIVE_CONTROL[8:7], MUX_RATE, FIXED_ROWS_SHOWN});
    cmd(8'h89);
    chk("addr control", 5'h01, ADDRESS_CONTROL);
    $display("test registers done");
    cmd(8'h0E);
    cmd(8'h19);
    cmd(8'h7F);
    chk("pointers", {8'h9E, 5'h1F}, {RAM_COLUMN, RAM_PAGE});
    xfer(1'b1, 1'b0, 8'hA1);
    xfer(1'b1, 1'b0, 8'hB2);
    chk("wrapped", {8'h00, 5'h00}, {RAM_COLUMN, RAM_PAGE});
    xfer(1'b1, 1'b0, 8'hC3);
    cmd(8'h00);
    cmd(8'h10);
    cmd(8'hEF);
    chk("cursor on", 1'b1, ADDRESS_CONTROL[3]);
    rd(1'b1, 8'hC3, "cursor read");
    chk("read holds column", 8'h00, RAM_COLUMN);
    xfer(1'b1, 1'b0, 8'hD4);
    xfer(1'b1, 1'b0, 8'hE5);
    chk("write advances", 8'h02, RAM_COLUMN);
    cmd(8'hEE);
    chk("cursor off", {1'b0, 8'h00}, {ADDRESS_CONTROL[3], RAM_COLUMN});
    rd(1'b1, 8'hD4, "data read");
    chk("read advances", 8'h01, RAM_COLUMN);
    cmd(8'h0E);
    cmd(8'h19);
    cmd(8'h7F);
    rd(1'b1, 8'hA1, "read back");
    $display("test addressing done");
    VENDOR_PIN <= 1'b1;
    rd(1'b0, 8'hFB, "status");
    VENDOR_PIN <= 1'b0;
    cmd(8'hC0);
    cmd(8'hAE);
    rd(1'b0, 8'h13, "status");
    $display("test status done");
    cmd(8'hF4);
    cmd(8'h10);
    cmd(8'hF6);
    cmd(8'h11);
    cmd(8'hF5);
    cmd(8'h02);
    cmd(8'hF7);
    cmd(8'h03);
    cmd(8'hF9);
    cmd(8'h01);
    cmd(8'h11);
    cmd(8'h62);
    xfer(1'b1, 1'b0, 8'h11);
    chk("window wrap", {8'h10, 5'h03, 5'h11}, {RAM_COLUMN, RAM_PAGE, ADDRESS_CONTROL});
    xfer(1'b1, 1'b0, 8'h22);
    xfer(1'b1, 1'b0, 8'h33);
    chk("window page wrap", {8'h10, 5'h02}, {RAM_COLUMN, RAM_PAGE});
    cmd(8'hF8);
    chk("window off", 5'h01, ADDRESS_CONTROL);
    $display("test window done");
    cmd(8'hE3);
    chk("nop", {7'h65, 8'h5A}, {SCROLL_LINE, BIAS_TRIM_LEVEL});
    cmd(8'hE2);
    chk("pending set", 1'b1, RESET_PENDING);
    cmd(8'h95);
    xfer(1'b1, 1'b0, 8'h77);
    xfer(1'b1, 1'b1, 8'h00);
    wait_ready;
    chk_def("command reset");
    cmd(8'h9A);
    @(posedge CLOCK);
    RESET_PIN_N <= 1'b0;
    @(posedge CLOCK);
    RESET_PIN_N <= 1'b1;
    #1;
    wait_ready;
    chk_def("pin reset");
    $display("test resets done");
    finish_test;
  end
endmodule
